/* include/hcm_cfg.svh */
// constants of the host command mailbox: i/o offsets, memory addresses, bit positions
// assumes a 10-bit host i/o address and a 16-bit processor memory address
//
// Operation
// RQ1 - host requests flag: write one, then zero
// RQ2 - handshake write lands at shadow 7F2Eh
// RQ3 - access register names written host location
// RQ4 - request only when bits 0, 4 low
// RQ5 - no attention flag toward host
// RQ6 - host drives all nvram control signals; the host end never writes the nvctl location 22Dh
// RQ7 - nvram serial bit returned at bit 6
// RQ8 - four consecutive byte-wide array locations
// RQ9 - host fills words before requesting flag
// RQ10 - device from top three bits; 23 commands
// RQ11 - host polls flag low, then reads results
// RQ12 - host sets flag, device clears it
// RQ13 - writes and reads use separate regions
// RQ14 - any window write raises access interrupt
// RQ15 - array write shows flag set to host
// RQ16 - low bit-0 handshake sets internal flag
// RQ17 - nvram read served before pending command
// RQ18 - results to read region, clear flags
// RQ19 - seven session pages, chosen by device
// RQ20 - command identity from low five bits
// RQ21 - host leaves words alone while flag set
`ifndef HCM_CFG_SVH
`define HCM_CFG_SVH

// ----------------------------------------------------------------------------
// host i/o locations
// ----------------------------------------------------------------------------
`define HCM_IO_ARRAY 10'h228
`define HCM_IO_NVCTL 10'h22D
`define HCM_IO_HANDSHAKE 10'h22E
`define HCM_IO_STROBE 10'h22F
`define HCM_IO_WIN_MASK 10'h3F8
`define HCM_IO_ARR_MASK 10'h3FC

// ----------------------------------------------------------------------------
// shared memory addresses seen by the processor
// ----------------------------------------------------------------------------
`define HCM_MEM_WR_ARRAY 16'h7F28
`define HCM_MEM_RD_ARRAY 16'h7E28
`define HCM_MEM_WR_HS 16'h7F2E
`define HCM_MEM_RD_HS 16'h7E2E
`define HCM_MEM_WR_STROBE 16'h7F2F
`define HCM_MEM_WR_NVCTL 16'h7F2D
`define HCM_MEM_ARR_MASK 16'hFFFC

// ----------------------------------------------------------------------------
// bit positions and values
// ----------------------------------------------------------------------------
`define HCM_HS_REQ_BIT 0
`define HCM_HS_NVEN_BIT 4
`define HCM_HS_FLAG_BIT 7
`define HCM_STB_CLK_BIT 7
`define HCM_STB_DATA_BIT 6
`define HCM_HS_REQ_VAL 8'h01
`define HCM_HS_NVEN_VAL 8'h10
`define HCM_STB_CLK_VAL 8'h80
`define HCM_CMD_COUNT 5'h17
`define HCM_SESSIONS 3'h7
`define HCM_NV_BITS 16

// ----------------------------------------------------------------------------
// host controller register offsets
// ----------------------------------------------------------------------------
`define HCM_CR_WORD0 4'h0
`define HCM_CR_GO 4'h4
`define HCM_CR_STATUS 4'h5
`define HCM_CR_RES0 4'h6
`define HCM_CR_RES3 4'h9
`define HCM_CR_NVBIT 4'hA
`define HCM_GO_CMD_BIT 0
`define HCM_GO_NV_BIT 1

`endif

/* include/hcm_pkg.sv */
// types of the host command mailbox
// assumes hcm_cfg.svh for the widths it names
`include "hcm_cfg.svh"

package hcm_pkg;

    // ------------------------------------------------------------------------
    // device end
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {T_IDLE, T_EXEC} hcm_task_e;

    typedef struct packed {
        logic [3:0][7:0] wr_arr;
        logic [3:0][7:0] rd_arr;
        logic [7:0] hs;
        logic [7:0] nvctl;
        logic [7:0] strobe;
        logic host_flag;
        logic int_flag;
        logic irq;
        logic [2:0] access;
        logic nv_pend;
        logic [`HCM_NV_BITS-1:0] nv_img;
        logic [7:0] io_rdata;
        logic [7:0] mem_rdata;
        logic [6:0][7:0] page;
        hcm_task_e task_st;
    } hcm_dev_s;

    // ------------------------------------------------------------------------
    // host end
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        H_IDLE, H_WARR, H_SET, H_CLR, H_POLL, H_PWAIT, H_RRD, H_RWAIT,
        H_NEN, H_NCLK, H_NRD, H_NWAIT, H_NLOW, H_NDIS
    } hcm_host_e;

    typedef struct packed {
        hcm_host_e st;
        logic [1:0] idx;
        logic [3:0][7:0] cmd;
        logic [3:0][7:0] res;
        logic busy;
        logic done;
        logic nvbit;
        logic [9:0] io_addr;
        logic io_wr;
        logic io_rd;
        logic [7:0] io_wdata;
        logic [7:0] rdata;
    } hcm_host_s;

endpackage

/* include/hcm_io_if.sv */
// host i/o bus between the pc host end and the mailbox device end
// assumes both ends run on one clock; read data follow a read by one cycle
`timescale 1ns/1ps

interface hcm_io_if;
    logic [9:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;

    modport host (output io_addr, output io_wr, output io_rd, output io_wdata, input io_rdata);
    modport dev (input io_addr, input io_wr, input io_rd, input io_wdata, output io_rdata);
endinterface // hcm_io_if

/* design/hcm_device.sv */
// device end of the host command mailbox: steering, flags, nvram emulation, task
// assumes a host on hcm_io_if and a processor that executes decoded commands
`timescale 1ns/1ps
`include "hcm_cfg.svh"

module hcm_device (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // host i/o bus
    hcm_io_if.dev io,
    // processor view of shared memory
    input wire logic [15:0] i_mem_addr,
    input wire logic i_mem_rd,
    output logic [7:0] o_mem_rdata,
    // host access notification
    output logic o_birq,
    output logic [2:0] o_access,
    input wire logic i_access_ack,
    // command task
    output logic o_cmd_valid,
    output logic o_cmd_known,
    output logic [4:0] o_cmd_id,
    output logic [2:0] o_cmd_dev,
    output logic [23:0] o_cmd_args,
    output logic [7:0] o_page_status,
    input wire logic i_done,
    input wire logic [31:0] i_result,
    input wire logic [7:0] i_status,
    // nvram image
    input wire logic i_nv_load,
    input wire logic [`HCM_NV_BITS-1:0] i_nv_image
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    hcm_pkg::hcm_dev_s r_reg;
    hcm_pkg::hcm_dev_s r_next;

    // address within a masked block
    function automatic logic io_in(input logic [9:0] a, input logic [9:0] m, input logic [9:0] b);
        io_in = ((a & m) == b);
    endfunction

    // session page index valid
    function automatic logic page_ok(input logic [2:0] d);
        page_ok = (d < `HCM_SESSIONS);
    endfunction

    logic [2:0] dev_sel;
    assign dev_sel = r_reg.wr_arr[0][7:5]; // RQ10

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.io_rdata = 8'h00;
        r_next.mem_rdata = 8'h00;

        // nvram image load from processor
        if (i_nv_load) begin
            r_next.nv_img = i_nv_image;
        end

        // servicing task
        case (r_reg.task_st)
            hcm_pkg::T_IDLE: begin
                if (r_reg.nv_pend) begin // RQ17
                    r_next.nv_img = {r_reg.nv_img[`HCM_NV_BITS-2:0], r_reg.nv_img[`HCM_NV_BITS-1]};
                    r_next.nv_pend = 1'b0;
                end else if (r_reg.int_flag) begin // RQ17
                    r_next.task_st = hcm_pkg::T_EXEC;
                end
            end
            hcm_pkg::T_EXEC: begin
                if (i_done) begin
                    r_next.rd_arr = i_result; // RQ18
                    if (page_ok(dev_sel)) begin
                        r_next.page[dev_sel] = i_status; // RQ19
                    end
                    r_next.int_flag = 1'b0; // RQ18
                    r_next.host_flag = 1'b0; // RQ12
                    r_next.task_st = hcm_pkg::T_IDLE;
                end
            end
            default: begin
                r_next.task_st = hcm_pkg::T_IDLE;
            end
        endcase

        // interrupt clear, then set so a new write wins
        if (i_access_ack) begin
            r_next.irq = 1'b0;
        end
        if (io.io_wr && io_in(io.io_addr, `HCM_IO_WIN_MASK, `HCM_IO_ARRAY)) begin
            r_next.irq = 1'b1; // RQ14
            r_next.access = io.io_addr[2:0]; // RQ3
        end

        // host writes steered into the write region
        if (io.io_wr) begin
            if (io_in(io.io_addr, `HCM_IO_ARR_MASK, `HCM_IO_ARRAY)) begin
                r_next.wr_arr[io.io_addr[1:0]] = io.io_wdata; // RQ13 RQ8
                r_next.host_flag = 1'b1; // RQ15
            end
            if (io.io_addr == `HCM_IO_NVCTL) begin
                r_next.nvctl = io.io_wdata;
            end
            if (io.io_addr == `HCM_IO_HANDSHAKE) begin
                r_next.hs = io.io_wdata; // RQ2
                if (!io.io_wdata[`HCM_HS_REQ_BIT] && !io.io_wdata[`HCM_HS_NVEN_BIT] && r_reg.host_flag) begin
                    r_next.int_flag = 1'b1; // RQ4 RQ16
                end
            end
            if (io.io_addr == `HCM_IO_STROBE) begin
                r_next.strobe = io.io_wdata;
                if (io.io_wdata[`HCM_STB_CLK_BIT] && !r_reg.strobe[`HCM_STB_CLK_BIT]
                    && r_reg.hs[`HCM_HS_NVEN_BIT]) begin
                    r_next.nv_pend = 1'b1;
                end
            end
        end

        // host reads sourced from the read region
        if (io.io_rd) begin
            if (io_in(io.io_addr, `HCM_IO_ARR_MASK, `HCM_IO_ARRAY)) begin
                r_next.io_rdata = r_reg.rd_arr[io.io_addr[1:0]]; // RQ13 RQ8
            end else if (io.io_addr == `HCM_IO_HANDSHAKE) begin
                // attention bit stays zero
                r_next.io_rdata[`HCM_HS_FLAG_BIT] = r_reg.host_flag; // RQ5 RQ12
            end else if (io.io_addr == `HCM_IO_STROBE) begin
                r_next.io_rdata[`HCM_STB_DATA_BIT] = r_reg.hs[`HCM_HS_NVEN_BIT]
                    & r_reg.nv_img[`HCM_NV_BITS-1]; // RQ7
            end
        end

        // processor reads of shared memory
        if (i_mem_rd) begin
            if ((i_mem_addr & `HCM_MEM_ARR_MASK) == `HCM_MEM_WR_ARRAY) begin
                r_next.mem_rdata = r_reg.wr_arr[i_mem_addr[1:0]];
            end else if ((i_mem_addr & `HCM_MEM_ARR_MASK) == `HCM_MEM_RD_ARRAY) begin
                r_next.mem_rdata = r_reg.rd_arr[i_mem_addr[1:0]];
            end else if (i_mem_addr == `HCM_MEM_WR_HS) begin
                r_next.mem_rdata = r_reg.hs; // RQ2
            end else if (i_mem_addr == `HCM_MEM_RD_HS) begin
                r_next.mem_rdata[`HCM_HS_FLAG_BIT] = r_reg.host_flag;
            end else if (i_mem_addr == `HCM_MEM_WR_STROBE) begin
                r_next.mem_rdata = r_reg.strobe;
            end else if (i_mem_addr == `HCM_MEM_WR_NVCTL) begin
                r_next.mem_rdata = r_reg.nvctl; // RQ6
            end
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign io.io_rdata = r_reg.io_rdata;
    assign o_mem_rdata = r_reg.mem_rdata;
    assign o_birq = r_reg.irq; // RQ14
    assign o_access = r_reg.access; // RQ3
    assign o_cmd_valid = (r_reg.task_st == hcm_pkg::T_EXEC);
    assign o_cmd_id = r_reg.wr_arr[0][4:0]; // RQ20
    assign o_cmd_known = (r_reg.wr_arr[0][4:0] < `HCM_CMD_COUNT); // RQ10
    assign o_cmd_dev = dev_sel;
    assign o_cmd_args = {r_reg.wr_arr[3], r_reg.wr_arr[2], r_reg.wr_arr[1]};
    assign o_page_status = page_ok(dev_sel) ? r_reg.page[dev_sel] : 8'h00; // RQ19

endmodule // hcm_device

/* design/hcm_host.sv */
// host end of the mailbox: issues commands and nvram bit reads over the i/o bus
// assumes a software master on the plain register port and hcm_device on the link
`timescale 1ns/1ps
`include "hcm_cfg.svh"

module hcm_host (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // host i/o bus
    hcm_io_if.host io,
    // software register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    hcm_pkg::hcm_host_s r_reg;
    hcm_pkg::hcm_host_s r_next;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.io_wr = 1'b0;
        r_next.io_rd = 1'b0;
        r_next.rdata = 8'h00;

        // software writes; words frozen while busy
        if (i_wr && !r_reg.busy) begin
            if (i_addr < `HCM_CR_GO) begin
                r_next.cmd[i_addr[1:0]] = i_wdata; // RQ21
            end else if (i_addr == `HCM_CR_GO) begin
                if (i_wdata[`HCM_GO_CMD_BIT]) begin
                    r_next.busy = 1'b1;
                    r_next.done = 1'b0;
                    r_next.idx = 2'h0;
                    r_next.io_wr = 1'b1; // RQ9
                    r_next.io_addr = `HCM_IO_ARRAY;
                    r_next.io_wdata = r_reg.cmd[0];
                    r_next.st = hcm_pkg::H_WARR;
                end else if (i_wdata[`HCM_GO_NV_BIT]) begin
                    r_next.busy = 1'b1;
                    r_next.done = 1'b0;
                    r_next.io_wr = 1'b1; // RQ6
                    r_next.io_addr = `HCM_IO_HANDSHAKE;
                    r_next.io_wdata = `HCM_HS_NVEN_VAL;
                    r_next.st = hcm_pkg::H_NEN;
                end
            end
        end

        // software reads
        if (i_rd) begin
            if (i_addr < `HCM_CR_GO) begin
                r_next.rdata = r_reg.cmd[i_addr[1:0]];
            end else if (i_addr == `HCM_CR_STATUS) begin
                r_next.rdata = {6'h00, r_reg.done, r_reg.busy};
            end else if (i_addr >= `HCM_CR_RES0 && i_addr <= `HCM_CR_RES3) begin
                r_next.rdata = r_reg.res[2'(i_addr - `HCM_CR_RES0)];
            end else if (i_addr == `HCM_CR_NVBIT) begin
                r_next.rdata = {7'h00, r_reg.nvbit};
            end
        end

        // bus sequencer
        case (r_reg.st)
            hcm_pkg::H_IDLE: begin
            end
            hcm_pkg::H_WARR: begin
                r_next.io_wr = 1'b1;
                if (r_reg.idx != 2'h3) begin
                    r_next.idx = r_reg.idx + 2'h1;
                    r_next.io_addr = `HCM_IO_ARRAY + {8'h00, r_next.idx}; // RQ8
                    r_next.io_wdata = r_reg.cmd[r_next.idx]; // RQ9
                end else begin
                    r_next.io_addr = `HCM_IO_HANDSHAKE;
                    r_next.io_wdata = `HCM_HS_REQ_VAL; // RQ1
                    r_next.st = hcm_pkg::H_SET;
                end
            end
            hcm_pkg::H_SET: begin
                r_next.io_wr = 1'b1;
                r_next.io_wdata = 8'h00; // RQ1 RQ12
                r_next.st = hcm_pkg::H_CLR;
            end
            hcm_pkg::H_CLR: begin
                r_next.io_rd = 1'b1;
                r_next.st = hcm_pkg::H_POLL;
            end
            hcm_pkg::H_POLL: begin
                r_next.st = hcm_pkg::H_PWAIT;
            end
            hcm_pkg::H_PWAIT: begin
                r_next.io_rd = 1'b1;
                if (io.io_rdata[`HCM_HS_FLAG_BIT]) begin
                    r_next.st = hcm_pkg::H_POLL; // RQ11
                end else begin
                    r_next.idx = 2'h0;
                    r_next.io_addr = `HCM_IO_ARRAY; // RQ11
                    r_next.st = hcm_pkg::H_RRD;
                end
            end
            hcm_pkg::H_RRD: begin
                r_next.st = hcm_pkg::H_RWAIT;
            end
            hcm_pkg::H_RWAIT: begin
                r_next.res[r_reg.idx] = io.io_rdata;
                if (r_reg.idx != 2'h3) begin
                    r_next.idx = r_reg.idx + 2'h1;
                    r_next.io_rd = 1'b1;
                    r_next.io_addr = `HCM_IO_ARRAY + {8'h00, r_next.idx};
                    r_next.st = hcm_pkg::H_RRD;
                end else begin
                    r_next.busy = 1'b0;
                    r_next.done = 1'b1;
                    r_next.st = hcm_pkg::H_IDLE;
                end
            end
            hcm_pkg::H_NEN: begin
                r_next.io_wr = 1'b1;
                r_next.io_addr = `HCM_IO_STROBE;
                r_next.io_wdata = `HCM_STB_CLK_VAL; // RQ6
                r_next.st = hcm_pkg::H_NCLK;
            end
            hcm_pkg::H_NCLK: begin
                r_next.io_rd = 1'b1;
                r_next.st = hcm_pkg::H_NRD;
            end
            hcm_pkg::H_NRD: begin
                r_next.st = hcm_pkg::H_NWAIT;
            end
            hcm_pkg::H_NWAIT: begin
                r_next.nvbit = io.io_rdata[`HCM_STB_DATA_BIT];
                r_next.io_wr = 1'b1;
                r_next.io_wdata = 8'h00; // RQ6
                r_next.st = hcm_pkg::H_NLOW;
            end
            hcm_pkg::H_NLOW: begin
                r_next.io_wr = 1'b1;
                r_next.io_addr = `HCM_IO_HANDSHAKE;
                r_next.io_wdata = 8'h00;
                r_next.st = hcm_pkg::H_NDIS;
            end
            hcm_pkg::H_NDIS: begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
                r_next.st = hcm_pkg::H_IDLE;
            end
            default: begin
                r_next.st = hcm_pkg::H_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign io.io_addr = r_reg.io_addr;
    assign io.io_wr = r_reg.io_wr;
    assign io.io_rd = r_reg.io_rd;
    assign io.io_wdata = r_reg.io_wdata;
    assign o_rdata = r_reg.rdata;

endmodule // hcm_host

/* test/hcm_properties.sv */
// checker on the host i/o bus joining the two mailbox ends
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "hcm_cfg.svh"

module hcm_properties (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // host i/o bus
    input wire logic [9:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    // ------------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    wire hs_wr = io_wr && io_addr == `HCM_IO_HANDSHAKE;
    wire arr = (io_addr & `HCM_IO_ARR_MASK) == `HCM_IO_ARRAY;
    wire win = (io_addr & `HCM_IO_WIN_MASK) == `HCM_IO_ARRAY;
    logic hs_rd_reg;
    logic flag_up_reg;
    logic nv_en_reg;

    // last polled flag and last written enable bit
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hs_rd_reg <= 1'b0;
            flag_up_reg <= 1'b0;
            nv_en_reg <= 1'b0;
        end else begin
            hs_rd_reg <= io_rd && io_addr == `HCM_IO_HANDSHAKE;
            if (hs_rd_reg) flag_up_reg <= io_rdata[7];
            if (hs_wr) nv_en_reg <= io_wdata[4];
        end
    end

    property p_toggle; hs_wr && io_wdata[0] |=> hs_wr && !io_wdata[0]; endproperty
    a_toggle: assert property (p_toggle) else $error("set bit not followed by clear");
    property p_no_attn; io_rd && io_addr == `HCM_IO_HANDSHAKE |=> io_rdata[6:0] == 7'h00; endproperty
    a_no_attn: assert property (p_no_attn) else $error("handshake read shows extra bits");
    property p_words_first; hs_wr && io_wdata[0] |-> $past(io_wr) && $past(io_addr) == 10'h22B; endproperty
    a_words_first: assert property (p_words_first) else $error("request before last word");
    property p_nv_bit; io_rd && io_addr == `HCM_IO_STROBE |=> (io_rdata & 8'hBF) == 8'h00; endproperty
    a_nv_bit: assert property (p_nv_bit) else $error("strobe read outside bit 6");
    property p_quiet; !io_rd |=> io_rdata == 8'h00; endproperty
    a_quiet: assert property (p_quiet) else $error("read data without read");
    property p_outside; io_rd && !win |=> io_rdata == 8'h00; endproperty
    a_outside: assert property (p_outside) else $error("read outside window not zero");
    property p_one_strobe; !(io_wr && io_rd); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("write and read together");
    property p_hold_words; flag_up_reg |-> !(io_wr && arr); endproperty
    a_hold_words: assert property (p_hold_words) else $error("array written while flag set");
    property p_poll_first; flag_up_reg |-> !(io_rd && arr); endproperty
    a_poll_first: assert property (p_poll_first) else $error("results read while flag set");
    property p_nv_enable; io_wr && io_addr == `HCM_IO_STROBE && io_wdata[7] |-> nv_en_reg; endproperty
    a_nv_enable: assert property (p_nv_enable) else $error("nvram clock without enable");

    c_cmd: cover property (hs_wr && io_wdata == 8'h01);
    c_flag: cover property (hs_rd_reg && io_rdata[7]);
    c_nv: cover property (io_rd && io_addr == `HCM_IO_STROBE);
endmodule // hcm_properties

/* test/host_command_mailbox_bench.sv */
// bench: host end and device end joined over the i/o bus
// assumes the bench plays software on the host port and the processor
`timescale 1ns/1ps
`include "hcm_cfg.svh"

module host_command_mailbox_bench;
    // ------------------------------------------------------------------
    // stimulus, instances and scenarios
    // ------------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0, i_rd = 1'b0, i_mem_rd = 1'b0;
    logic i_access_ack = 1'b0, i_done = 1'b0, i_nv_load = 1'b0;
    logic [15:0] i_mem_addr = 16'h0000;
    logic [31:0] i_result = 32'h0;
    logic [7:0] i_status = 8'h00;
    logic [`HCM_NV_BITS-1:0] i_nv_image = 16'h0000;
    logic [7:0] o_rdata, o_mem_rdata, o_page_status;
    logic o_birq, o_cmd_valid, o_cmd_known;
    logic [2:0] o_access, o_cmd_dev;
    logic [4:0] o_cmd_id;
    logic [23:0] o_cmd_args;
    int bad_count = 0, n_checks = 0, cyc = 0;

    // 10 mhz clock
    always #50 i_clk = ~i_clk;

    hcm_io_if bus ();
    hcm_host i_hcm_host (.i_clk, .i_srst, .io(bus), .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
    hcm_device i_hcm_device (.i_clk, .i_srst, .io(bus), .i_mem_addr, .i_mem_rd, .o_mem_rdata, .o_birq,
        .o_access, .i_access_ack, .o_cmd_valid, .o_cmd_known, .o_cmd_id, .o_cmd_dev, .o_cmd_args,
        .o_page_status, .i_done, .i_result, .i_status, .i_nv_load, .i_nv_image);
    hcm_properties i_hcm_properties (.i_clk, .i_srst, .io_addr(bus.io_addr), .io_wr(bus.io_wr),
        .io_rd(bus.io_rd), .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata));

    // counts and verdict
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // software write, one cycle strobe
    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // software read, data the cycle after
    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    // processor read of shared memory
    task automatic mem_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_mem_addr <= a;
        i_mem_rd <= 1'b1;
        @(posedge i_clk);
        i_mem_rd <= 1'b0;
        #1 d = o_mem_rdata;
    endtask

    // poll host status until done, bounded
    task automatic wait_done();
        logic [7:0] d;
        int n;
        n = 0;
        d = 8'h00;
        while (d[1] !== 1'b1 && n < 200) begin
            sw_rd(4'h5, d);
            n++;
        end
        chk(d, 8'h02);
    endtask

    // acknowledge the access notification
    task automatic ack();
        @(posedge i_clk);
        i_access_ack <= 1'b1;
        @(posedge i_clk);
        i_access_ack <= 1'b0;
        #1 chk(o_birq, 1'b0);
    endtask

    // one full command with processor side answering
    task automatic t_command(input logic [31:0] w, input logic [31:0] r, input logic [7:0] s);
        logic [7:0] d;
        int n;
        for (int k = 0; k < 4; k++) sw_wr(k[3:0], w[8*k +: 8]);
        sw_wr(4'h4, 8'h01);
        n = 0;
        while (o_cmd_valid !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        #1 chk(o_cmd_valid, 1'b1);
        chk(o_cmd_id, w[4:0]);
        chk(o_cmd_dev, w[7:5]);
        chk(o_cmd_known, w[4:0] < 5'h17);
        chk(o_cmd_args, w[31:8]);
        chk(o_birq, 1'b1);
        chk(o_access, 3'h6);
        sw_rd(4'h5, d);
        chk(d, 8'h01);
        sw_wr(4'h0, ~w[7:0]);
        sw_rd(4'h0, d);
        chk(d, w[7:0]);
        mem_rd(16'h7F28, d);
        chk(d, w[7:0]);
        mem_rd(16'h7F2E, d);
        chk(d, 8'h00);
        mem_rd(16'h7E2E, d);
        chk(d, 8'h80);
        ack();
        @(posedge i_clk);
        i_result <= r;
        i_status <= s;
        i_done <= 1'b1;
        @(posedge i_clk);
        i_done <= 1'b0;
        wait_done();
        for (int k = 0; k < 4; k++) begin
            sw_rd(4'h6 + k[3:0], d);
            chk(d, r[8*k +: 8]);
        end
        chk(o_cmd_valid, 1'b0);
        chk(o_page_status, (w[7:5] == 3'h7) ? 8'h00 : s);
        mem_rd(16'h7E28, d);
        chk(d, r[7:0]);
        mem_rd(16'h7E2E, d);
        chk(d, 8'h00);
    endtask

    // emulated nvram read, bits msb first
    task automatic t_nvram(input logic [15:0] img);
        logic [7:0] d;
        @(posedge i_clk);
        i_nv_image <= img;
        i_nv_load <= 1'b1;
        @(posedge i_clk);
        i_nv_load <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            sw_wr(4'h4, 8'h02);
            wait_done();
            sw_rd(4'hA, d);
            chk(d, {7'h00, img[15-k]});
        end
        chk(o_access, 3'h6);
        mem_rd(16'h7F2F, d);
        chk(d, 8'h00);
        mem_rd(16'h7F2D, d);
        chk(d, 8'h00);
        ack();
    endtask

    // main sequence
    initial begin
        logic [7:0] d;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        sw_rd(4'hB, d);
        chk(d, 8'h00);
        chk(o_birq, 1'b0);
        t_command(32'h33221116, 32'hA1B2C3D4, 8'h5A);
        t_command(32'h00000057, 32'h0F1E2D3C, 8'h81);
        t_command(32'hC0B0A0E0, 32'h11223344, 8'h7E);
        t_nvram(16'hA3C5);
        t_command(32'h00000021, 32'hFFEE0001, 8'h03);
        give_verdict();
    end

    // hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
endmodule // host_command_mailbox_bench
